// [bench/fps_link_chk.sv]
// Checker for the programming link between the host and device ends.
// Assumes it sits beside the link interface and sees its signals directly.
`timescale 1ns/1ps
module fps_link_chk
	import fps_pkg::*;
#(
	parameter int unsigned ENTRY_CYC = ENTRY_WAIT_CYC,
	parameter logic [11:0] BIT_CYC = UART_BIT_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	input wire logic chip_reset_low,
	input wire logic program_mode_enable_low,
	input wire logic port_select_low,
	input wire logic port_serial_clock,
	input wire logic port_command_in,
	input wire logic port_data_out,
	input wire logic port_data_oe,
	input wire logic unlock_receive_a
);
	// ==========================================================
	// Helper counters
	logic [31:0] entry_cnt;
	logic [15:0] low_cnt;

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			entry_cnt <= 32'h0;
		else if (chip_reset_low || program_mode_enable_low)
			entry_cnt <= 32'h0;
		else if (entry_cnt < ENTRY_CYC)
			entry_cnt <= entry_cnt + 32'h1;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			low_cnt <= 16'h0;
		else if (unlock_receive_a)
			low_cnt <= 16'h0;
		else if (low_cnt != 16'hFFFF)
			low_cnt <= low_cnt + 16'h1;
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_b_i);

	a_entry_wait: assert property ($fell(port_select_low) |-> entry_cnt >= ENTRY_CYC)
		else $error("select fell before entry wait");
	a_entry_order: assert property ($fell(chip_reset_low) |-> !program_mode_enable_low)
		else $error("reset fell without program enable");
	a_reset_high: assert property ($fell(program_mode_enable_low) |-> chip_reset_low [*8])
		else $error("reset not held high after enable");
	a_sclk_high: assert property ($rose(port_serial_clock) |-> port_serial_clock [*3])
		else $error("serial clock high too short");
	a_sclk_low: assert property ($fell(port_serial_clock) |-> !port_serial_clock [*3])
		else $error("serial clock low too short");
	a_sclk_idle: assert property (port_select_low |-> !port_serial_clock)
		else $error("serial clock high outside command");
	a_cmd_stable: assert property (port_serial_clock && $past(port_serial_clock) |-> $stable(port_command_in))
		else $error("command bit moved while clock high");
	a_data_hold: assert property (port_data_oe && $rose(port_serial_clock) |=> $stable(port_data_out) [*4])
		else $error("data moved after rising edge");
	a_oe_idle: assert property (port_select_low [*6] |-> !port_data_oe && port_data_out)
		else $error("data driven while deselected");
	a_uart_bit: assert property ($rose(unlock_receive_a) |-> low_cnt >= {4'h0, BIT_CYC} - 16'h1)
		else $error("unlock line low shorter than a bit");

	c_select: cover property ($fell(port_select_low));
	c_oe: cover property ($fell(port_data_oe));
	c_uart: cover property ($rose(unlock_receive_a));
endmodule : fps_link_chk

// [bench/test_flash_program_slave_port.sv]
// Testbench joining host and device ends through the link interface.
// Assumes short entry and unlock bit timing on both ends and a locked device.
`timescale 1ns/1ps
module test_flash_program_slave_port
	import fps_pkg::*;
;
	localparam int unsigned T_ENTRY = 200;
	localparam logic [11:0] T_BIT = 12'h0D0; // Shortened unlock bit time keeps the run short.
	localparam logic [15:0] T_ID = 16'h5A3C; // Arbitrary identifier value.
	localparam logic [31:0] T_KEY = 32'hA5C31E77;
	logic clk_sys_i, rst_b_i, enter_i, unlock_i, start_i, ready_o, rd_valid_o, wr_take_o;
	logic mode_active_o, unlocked_o, halted_o, busy_o;
	logic [7:0] op_i, wr_byte, rd_data_o;
	logic [23:0] addr_i;
	logic [15:0] count_i;
	logic [31:0] key_i;
	logic [7:0] rq[$];
	int fails, n_checks;

	// ==========================================================
	// Design under test
	fps_link_if fps_link_if_inst();
	fps_device #(.ENTRY_CYC(T_ENTRY), .MEM_BYTES(4096), .ID_CODE(T_ID), .BIT_CYC(T_BIT)) fps_device_inst (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link(fps_link_if_inst.device_mp),
		.lock_enable_i(1'b1), .lock_key_i(T_KEY), .mode_active_o(mode_active_o),
		.unlocked_o(unlocked_o), .halted_o(halted_o), .busy_o(busy_o));
	fps_host #(.RST_HIGH_CYC(20), .ENTRY_CYC(T_ENTRY), .BIT_CYC(T_BIT)) fps_host_inst (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .link(fps_link_if_inst.host_mp),
		.enter_i(enter_i), .unlock_i(unlock_i), .key_i(key_i), .start_i(start_i), .op_i(op_i),
		.addr_i(addr_i), .count_i(count_i), .wr_data_i(wr_byte), .ready_o(ready_o),
		.rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .wr_take_o(wr_take_o));
	fps_link_chk #(.ENTRY_CYC(T_ENTRY), .BIT_CYC(T_BIT)) fps_link_chk_inst (
		.clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .chip_reset_low(fps_link_if_inst.chip_reset_low),
		.program_mode_enable_low(fps_link_if_inst.program_mode_enable_low),
		.port_select_low(fps_link_if_inst.port_select_low),
		.port_serial_clock(fps_link_if_inst.port_serial_clock),
		.port_command_in(fps_link_if_inst.port_command_in),
		.port_data_out(fps_link_if_inst.port_data_out), .port_data_oe(fps_link_if_inst.port_data_oe),
		.unlock_receive_a(fps_link_if_inst.unlock_receive_a));

	// ==========================================================
	// Clock, read collector and write data supply
	initial
	begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end

	always @(posedge clk_sys_i)
	begin
		if (rd_valid_o === 1'b1)
			rq.push_back(rd_data_o);
		if (wr_take_o === 1'b1)
			wr_byte <= wr_byte + 8'h01;
	end

	// ==========================================================
	// Tasks
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic wait_ready(input int lim);
		int k;
		k = 0;
		while (ready_o !== 1'b1 && k < lim)
		begin
			@(posedge clk_sys_i);
			k++;
		end
		check("ready", {31'h0, ready_o}, 32'h1);
	endtask : wait_ready

	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [15:0] n);
		rq.delete();
		@(posedge clk_sys_i);
		op_i <= op;
		addr_i <= a;
		count_i <= n;
		start_i <= 1'b1;
		@(posedge clk_sys_i);
		start_i <= 1'b0;
		@(posedge clk_sys_i);
		wait_ready(20000);
	endtask : cmd

	task automatic cmp_q(input string nm, input logic [7:0] mask, input logic [7:0] e[$]);
		check(nm, 32'(rq.size()), 32'(e.size()));
		foreach (e[i])
			check(nm, {24'h0, rq[i] & mask}, {24'h0, e[i]});
	endtask : cmp_q

	task automatic endt(input string nm);
		$display("test %s done", nm);
	endtask : endt

	task automatic results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : results

	// ==========================================================
	// Tests
	initial
	begin
		repeat (60000) @(posedge clk_sys_i);
		fails++;
		results();
	end

	initial
	begin
		rst_b_i = 1'b0;
		enter_i = 1'b0;
		unlock_i = 1'b0;
		start_i = 1'b0;
		op_i = 8'h00;
		addr_i = 24'h0;
		count_i = 16'h0;
		wr_byte = 8'h00;
		key_i = 32'h0;
		repeat (12) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		@(posedge clk_sys_i);
		enter_i <= 1'b1;
		@(posedge clk_sys_i);
		enter_i <= 1'b0;
		wait_ready(2000);
		check("mode", {31'h0, mode_active_o}, 32'h1);
		endt("entry");
		cmd(OP_READ_ID, 24'h0, 16'h2);
		cmp_q("locked id", 8'hFF, '{8'h00, 8'h00});
		cmd(OP_READ_STATUS, 24'h0, 16'h2);
		cmp_q("status", 8'hFC, '{8'h9C, 8'h9C});
		endt("locked");
		@(posedge clk_sys_i);
		key_i <= T_KEY;
		unlock_i <= 1'b1;
		@(posedge clk_sys_i);
		unlock_i <= 1'b0;
		@(posedge clk_sys_i);
		wait_ready(30000);
		check("unlock", {30'h0, unlocked_o, halted_o}, 32'h2);
		cmd(OP_READ_ID, 24'h0, 16'h2);
		cmp_q("id", 8'hFF, '{T_ID[15:8], T_ID[7:0]});
		endt("unlock");
		cmd(OP_BULK_ERASE, 24'h0, 16'h0);
		cmd(OP_READ, 24'h000F00, 16'h2);
		cmp_q("bulk", 8'hFF, '{8'hFF, 8'hFF});
		wr_byte <= 8'h01;
		cmd(OP_WRITE_PROG, 24'h0007FC, 16'h8);
		cmd(OP_PAGE_ERASE, 24'h000ABC, 16'h0);
		check("busy", {31'h0, busy_o}, 32'h0);
		cmd(OP_READ, 24'h0007FC, 16'h8);
		cmp_q("data", 8'hFF, '{8'h01, 8'h02, 8'h03, 8'h04, 8'hFF, 8'hFF, 8'hFF, 8'hFF});
		endt("flash");
		cmd(8'h77, 24'h0, 16'h1);
		cmp_q("unknown", 8'hFF, '{8'h00});
		cmd(OP_READ_STATUS, 24'h0, 16'h1);
		cmp_q("status2", 8'hFC, '{8'h9C});
		endt("opcode");
		results();
	end
endmodule : test_flash_program_slave_port

// [hdl/fps_device.sv]
// Device end: flash emulator behind the programming serial port, with UART unlock.
// Assumes all link pins are asynchronous to clk_sys_i; they are synchronised here.
// Contract
// - Accept commands 10ms after both entry pins low.
// - Host keeps serial clock at most 3.33 MHz.
// - Select fall starts command; opcode then bytes.
// - Command input sampled on rising edge, MSB first.
// - Data out changes on falling edge.
// - Locked part refuses memory access until unlocked.
// - Unlock accepted on all three receive pins.
// - Unlock link 9600 baud, 8N1.
// - Unlock is cookie then key LSB first.
// - First matching attempt unlocks temporarily.
// - Mismatch halts programming until reset.
// - First pin delivering a byte is kept.
// - Permanent unlock rewrites first page without key; no permanent unlock is implemented here.
// - Host erases before programming.
// - Host writes at most 16KB per command.
// - Host polls status after erase and program.
// - Host holds reset high 1ms, then low.
// - Decode the six documented opcodes.
// - Status: ready MSB, then 0,0,1,1,1, two undefined.
// - Page erase clears 2048-byte page.
// - Bulk erase only with key 0x94809A.
`timescale 1ns/1ps
module fps_device
	import fps_pkg::*;
#(
	parameter int unsigned ENTRY_CYC = ENTRY_WAIT_CYC,
	parameter int unsigned MEM_BYTES = FLASH_BYTES,
	parameter logic [15:0] ID_CODE = 16'h5A3C,
	parameter logic [11:0] BIT_CYC = UART_BIT_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	fps_link_if.device_mp link,
	input wire logic lock_enable_i,
	input wire logic [31:0] lock_key_i,
	output logic mode_active_o,
	output logic unlocked_o,
	output logic halted_o,
	output logic busy_o
);
	// ID_CODE default value is arbitrary.

	localparam int AW = $clog2(MEM_BYTES);

	typedef enum logic [1:0] {
		U_HUNT = 2'b00,
		U_START = 2'b01,
		U_DATA = 2'b10,
		U_STOP = 2'b11
	} fps_uart_type;

	// ==========================================================
	// Decoders
	function automatic logic op_known(input logic [7:0] op);
		return op == OP_READ_ID || op == OP_READ_STATUS || fps_has_addr(op);
	endfunction : op_known

	function automatic logic [7:0] tx_pick(input logic [7:0] op, input logic [2:0] idx,
		input logic [7:0] status, input logic [7:0] rd);
		case (op)
			OP_READ_ID: return (idx == 3'h0) ? ID_CODE[15:8] : ((idx == 3'h1) ? ID_CODE[7:0] : 8'h00);
			OP_READ_STATUS: return status;
			OP_READ: return (idx >= 3'h3) ? rd : 8'h00;
			default: return 8'h00;
		endcase
	endfunction : tx_pick

	// ==========================================================
	// Pin synchronisers
	logic [7:0] mem [MEM_BYTES];
	logic [7:0] pin_raw;
	logic [7:0] pin_s1;
	logic [7:0] pin_s2;
	logic [7:0] pin_d;
	logic [31:0] entry_cnt;

	assign pin_raw = {link.chip_reset_low, link.program_mode_enable_low, link.port_select_low,
		link.port_serial_clock, link.port_command_in, link.unlock_receive_c, link.unlock_receive_b,
		link.unlock_receive_a};

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			pin_d <= PIN_IDLE;
		end
		else
		begin
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_d <= pin_s2;
		end
	end

	// ==========================================================
	// Entry into programming mode
	wire both_low = !pin_s2[7] && !pin_s2[6];

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			entry_cnt <= 32'h0;
			mode_active_o <= 1'b0;
		end
		else if (!both_low)
		begin
			entry_cnt <= 32'h0;
			mode_active_o <= 1'b0;
		end
		else if (entry_cnt == ENTRY_CYC - 1)
			mode_active_o <= 1'b1;
		else
			entry_cnt <= entry_cnt + 32'h1;
	end

	// ==========================================================
	// Serial port command engine
	logic [2:0] bit_cnt;
	logic [2:0] byte_idx;
	logic [6:0] rx_shift;
	logic [7:0] opcode;
	logic [23:0] addr;
	logic [7:0] tx_shift;
	logic dead;
	logic [AW-1:0] er_ptr;
	logic [AW-1:0] er_last;

	wire sel_fall = pin_d[5] & ~pin_s2[5];
	wire sck_rise = ~pin_d[4] & pin_s2[4];
	wire sck_fall = pin_d[4] & ~pin_s2[4];
	wire port_ok = mode_active_o & ~halted_o;
	wire mem_ok = ~lock_enable_i | unlocked_o;
	wire live = port_ok & ~pin_s2[5] & ~dead;
	wire [7:0] rx_byte = {rx_shift, pin_s2[3]};
	wire byte_done = live & sck_rise & (bit_cnt == 3'h7);
	wire [7:0] cur_op = (byte_idx == 3'h0) ? rx_byte : opcode;
	wire [23:0] next_addr = {addr[15:0], rx_byte};
	wire addr_last = byte_done & (byte_idx == 3'h3);
	wire [AW-1:0] rd_addr = (byte_idx == 3'h3) ? next_addr[AW-1:0] : addr[AW-1:0];
	wire [7:0] status = {~busy_o, STATUS_FIXED, 2'b00};
	wire [7:0] tx_load = tx_pick(cur_op, byte_idx, status, mem[rd_addr]);
	wire bad_op = (byte_idx == 3'h0) && (!op_known(rx_byte) || (rx_byte != OP_READ_STATUS && !mem_ok));
	wire start_page = addr_last & (opcode == OP_PAGE_ERASE) & ~busy_o;
	wire start_bulk = addr_last & (opcode == OP_BULK_ERASE) & (next_addr == BULK_KEY) & ~busy_o;
	wire prog_wr = byte_done & (byte_idx == 3'h4) & (opcode == OP_WRITE_PROG) & ~busy_o;
	wire [2:0] idx_step = (byte_idx == 3'h4) ? 3'h4 : byte_idx + 3'h1;
	wire [23:0] addr_step = (byte_idx == 3'h4) ? addr + 24'h1 :
		((byte_idx == 3'h3 && opcode == OP_READ) ? next_addr + 24'h1 : next_addr);

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
			rx_shift <= 7'h00;
			opcode <= 8'h00;
			addr <= 24'h0;
			tx_shift <= 8'h00;
			dead <= 1'b0;
		end
		else if (sel_fall)
		begin
			bit_cnt <= 3'h0;
			byte_idx <= 3'h0;
			tx_shift <= 8'h00;
			dead <= 1'b0;
		end
		else if (live & sck_rise)
		begin
			rx_shift <= rx_byte[6:0];
			bit_cnt <= bit_cnt + 3'h1;
			if (bit_cnt == 3'h7)
			begin
				tx_shift <= tx_load;
				dead <= bad_op;
				byte_idx <= idx_step;
				addr <= addr_step;
				if (byte_idx == 3'h0)
					opcode <= rx_byte;
			end
		end
		else if (live & sck_fall)
			tx_shift <= {tx_shift[6:0], 1'b0};
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			link.port_data_out <= 1'b1;
			link.port_data_oe <= 1'b0;
		end
		else if (pin_s2[5] | ~port_ok)
		begin
			link.port_data_out <= 1'b1;
			link.port_data_oe <= 1'b0;
		end
		else
		begin
			link.port_data_oe <= 1'b1;
			if (sck_fall & ~dead)
				link.port_data_out <= tx_shift[7];
		end
	end

	// ==========================================================
	// Erase engine and flash array
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			busy_o <= 1'b0;
			er_ptr <= '0;
			er_last <= '0;
		end
		else if (busy_o)
		begin
			busy_o <= (er_ptr != er_last);
			er_ptr <= er_ptr + 1'b1;
		end
		else if (start_page)
		begin
			busy_o <= 1'b1;
			er_ptr <= {next_addr[AW-1:PAGE_LSB], {PAGE_LSB{1'b0}}};
			er_last <= {next_addr[AW-1:PAGE_LSB], {PAGE_LSB{1'b1}}};
		end
		else if (start_bulk)
		begin
			busy_o <= 1'b1;
			er_ptr <= '0;
			er_last <= '1;
		end
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (busy_o)
			mem[er_ptr] <= ERASED_BYTE;
		else if (prog_wr)
			mem[addr[AW-1:0]] <= rx_byte;
	end

	// ==========================================================
	// UART unlock receiver
	fps_uart_type u_state;
	logic [11:0] u_tmr;
	logic [1:0] u_pin;
	logic [2:0] u_nbits;
	logic [2:0] u_nbytes;
	logic [7:0] u_shift;
	logic u_ok;

	wire [2:0] u_fall = pin_d[2:0] & ~pin_s2[2:0];
	wire [1:0] first_pin = u_fall[0] ? 2'd0 : (u_fall[1] ? 2'd1 : 2'd2);
	wire u_go = (u_nbytes == 3'h0) ? |u_fall : u_fall[u_pin];
	wire u_line = pin_s2[u_pin];
	wire u_en = mode_active_o & lock_enable_i & ~unlocked_o & ~halted_o;
	wire u_match = u_ok & u_line & (u_shift == fps_unlock_byte(u_nbytes, lock_key_i));

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			u_state <= U_HUNT;
			u_tmr <= 12'h000;
			u_pin <= 2'd0;
			u_nbits <= 3'h0;
			u_nbytes <= 3'h0;
			u_shift <= 8'h00;
			u_ok <= 1'b1;
			unlocked_o <= 1'b0;
			halted_o <= 1'b0;
		end
		else
		begin
			case (u_state)
				U_HUNT:
				begin
					if (u_en & u_go)
					begin
						if (u_nbytes == 3'h0)
							u_pin <= first_pin;
						u_tmr <= {1'b0, BIT_CYC[11:1]};
						u_state <= U_START;
					end
				end
				U_START:
				begin
					u_tmr <= u_tmr - 12'h001;
					if (u_tmr == 12'h000)
					begin
						u_tmr <= BIT_CYC - 12'h001;
						u_nbits <= 3'h0;
						u_state <= u_line ? U_HUNT : U_DATA;
					end
				end
				U_DATA:
				begin
					u_tmr <= u_tmr - 12'h001;
					if (u_tmr == 12'h000)
					begin
						u_shift <= {u_line, u_shift[7:1]};
						u_nbits <= u_nbits + 3'h1;
						u_tmr <= BIT_CYC - 12'h001;
						if (u_nbits == 3'h7)
							u_state <= U_STOP;
					end
				end
				U_STOP:
				begin
					u_tmr <= u_tmr - 12'h001;
					if (u_tmr == 12'h000)
					begin
						u_state <= U_HUNT;
						u_ok <= u_match;
						u_nbytes <= u_nbytes + 3'h1;
						if (u_nbytes == 3'h7)
						begin
							unlocked_o <= u_match;
							halted_o <= ~u_match;
						end
					end
				end
				default: u_state <= U_HUNT;
			endcase
		end
	end

endmodule : fps_device

// [hdl/fps_host.sv]
// Host end: enters programming mode, sends unlock over UART and runs port commands.
// Assumes the device end samples all pins with its own clock.
`timescale 1ns/1ps
module fps_host
	import fps_pkg::*;
#(
	parameter int unsigned RST_HIGH_CYC = RESET_HIGH_CYC,
	parameter int unsigned ENTRY_CYC = ENTRY_WAIT_CYC,
	parameter int unsigned SCLK_HALF = SCLK_HALF_MIN * 2,
	parameter logic [11:0] BIT_CYC = UART_BIT_CYC
)
(
	input wire logic clk_sys_i,
	input wire logic rst_b_i,
	fps_link_if.host_mp link,
	input wire logic enter_i,
	input wire logic unlock_i,
	input wire logic [31:0] key_i,
	input wire logic start_i,
	input wire logic [7:0] op_i,
	input wire logic [23:0] addr_i,
	input wire logic [15:0] count_i,
	input wire logic [7:0] wr_data_i,
	output logic ready_o,
	output logic [7:0] rd_data_o,
	output logic rd_valid_o,
	output logic wr_take_o
);

	typedef enum logic [2:0] {
		H_OFF = 3'b000,
		H_PRE = 3'b001,
		H_WAIT = 3'b010,
		H_IDLE = 3'b011,
		H_UART = 3'b100,
		H_SPI = 3'b101,
		H_END = 3'b110,
		H_GAP = 3'b111
	} fps_host_type;

	function automatic logic [7:0] host_byte(input logic [7:0] op, input logic [23:0] a,
		input logic [16:0] bi, input logic [7:0] wd);
		logic [23:0] h;
		h = (op == OP_BULK_ERASE) ? BULK_KEY : a;
		if (bi == 17'h0)
			return op;
		else if (fps_has_addr(op) && bi <= 17'h3)
			return h[8 * (3 - bi[1:0]) +: 8];
		else
			return (op == OP_WRITE_PROG) ? wd : 8'h00;
	endfunction : host_byte

	// ==========================================================
	// Registers and decode
	fps_host_type state;
	logic [31:0] tmr;
	logic [16:0] bi;
	logic [16:0] tot;
	logic [3:0] nbit;
	logic [2:0] ubyte;
	logic [9:0] sh;
	logic [7:0] rsh;
	logic [7:0] op;
	logic [23:0] addr;
	logic [31:0] key;
	logic m1;
	logic m2;
	logic poll;
	logic need_poll;
	logic last_rdy;

	wire [16:0] hdr = fps_has_addr(op) ? 17'h3 : 17'h0;
	wire [16:0] cnt_in = (op_i == OP_WRITE_PROG && {1'b0, count_i} > MAX_WRITE_BYTES) ?
		MAX_WRITE_BYTES : {1'b0, count_i};
	wire [16:0] hdr_in = fps_has_addr(op_i) ? 17'h3 : 17'h0;
	wire [7:0] tx_next = host_byte(op, addr, bi + 17'h1, wr_data_i);
	wire half_end = (tmr == SCLK_HALF - 1);
	wire is_data = (bi > hdr) && (op != OP_WRITE_PROG);
	wire repoll = need_poll && !(poll && last_rdy);

	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			m1 <= 1'b1;
			m2 <= 1'b1;
		end
		else
		begin
			m1 <= link.port_data_line;
			m2 <= m1;
		end
	end

	// ==========================================================
	// Sequencer
	always_ff @(posedge clk_sys_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state <= H_OFF;
			tmr <= 32'h0;
			bi <= 17'h0;
			tot <= 17'h0;
			nbit <= 4'h0;
			ubyte <= 3'h0;
			sh <= 10'h3FF;
			rsh <= 8'h00;
			op <= 8'h00;
			addr <= 24'h0;
			key <= 32'h0;
			poll <= 1'b0;
			need_poll <= 1'b0;
			last_rdy <= 1'b0;
			ready_o <= 1'b0;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			wr_take_o <= 1'b0;
			link.chip_reset_low <= 1'b1;
			link.program_mode_enable_low <= 1'b1;
			link.port_select_low <= 1'b1;
			link.port_serial_clock <= 1'b0;
			link.port_command_in <= 1'b0;
			link.unlock_receive_a <= 1'b1;
			link.unlock_receive_b <= 1'b1;
			link.unlock_receive_c <= 1'b1;
		end
		else
		begin
			rd_valid_o <= 1'b0;
			wr_take_o <= 1'b0;
			tmr <= tmr + 32'h1;
			case (state)
				H_OFF:
				begin
					tmr <= 32'h0;
					if (enter_i)
					begin
						link.program_mode_enable_low <= 1'b0;
						state <= H_PRE;
					end
				end
				H_PRE:
				begin
					if (tmr == RST_HIGH_CYC - 1)
					begin
						link.chip_reset_low <= 1'b0;
						tmr <= 32'h0;
						state <= H_WAIT;
					end
				end
				H_WAIT:
				begin
					if (tmr == ENTRY_CYC + ENTRY_MARGIN_CYC - 1)
					begin
						ready_o <= 1'b1;
						state <= H_IDLE;
					end
				end
				H_IDLE:
				begin
					tmr <= 32'h0;
					if (unlock_i)
					begin
						ready_o <= 1'b0;
						key <= key_i;
						ubyte <= 3'h0;
						nbit <= 4'h0;
						sh <= {1'b1, fps_unlock_byte(3'h0, key_i), 1'b0};
						state <= H_UART;
					end
					else if (start_i)
					begin
						ready_o <= 1'b0;
						op <= op_i;
						addr <= addr_i;
						tot <= 17'h1 + hdr_in + cnt_in;
						need_poll <= op_i == OP_PAGE_ERASE || op_i == OP_BULK_ERASE || op_i == OP_WRITE_PROG;
						poll <= 1'b0;
						bi <= 17'h0;
						nbit <= 4'h0;
						sh <= {2'b00, op_i};
						link.port_command_in <= op_i[7];
						link.port_select_low <= 1'b0;
						state <= H_SPI;
					end
				end
				H_UART:
				begin
					if (tmr[11:0] == BIT_CYC - 12'h001 || nbit == 4'h0)
					begin
						tmr <= 32'h0;
						nbit <= nbit + 4'h1;
						link.unlock_receive_a <= sh[0];
						sh <= {1'b1, sh[9:1]};
						if (nbit == 4'hA)
						begin
							link.unlock_receive_a <= 1'b1;
							nbit <= 4'h0;
							ubyte <= ubyte + 3'h1;
							sh <= {1'b1, fps_unlock_byte(ubyte + 3'h1, key), 1'b0};
							if (ubyte == 3'h7)
							begin
								ready_o <= 1'b1;
								state <= H_IDLE;
							end
						end
					end
				end
				H_SPI:
				begin
					if (half_end)
					begin
						tmr <= 32'h0;
						link.port_serial_clock <= ~link.port_serial_clock;
						if (!link.port_serial_clock)
							rsh <= {rsh[6:0], m2};
						else if (nbit == 4'h7)
						begin
							nbit <= 4'h0;
							if (is_data && !poll)
							begin
								rd_data_o <= rsh;
								rd_valid_o <= 1'b1;
							end
							if (poll && bi == 17'h1)
								last_rdy <= rsh[7];
							if (bi == tot - 17'h1)
								state <= H_END;
							else
							begin
								bi <= bi + 17'h1;
								sh <= {2'b00, tx_next};
								link.port_command_in <= tx_next[7];
								wr_take_o <= (op == OP_WRITE_PROG) && (bi + 17'h1 > hdr);
							end
						end
						else
						begin
							nbit <= nbit + 4'h1;
							sh <= {sh[8:0], 1'b0};
							link.port_command_in <= sh[6];
						end
					end
				end
				H_END:
				begin
					if (half_end)
					begin
						tmr <= 32'h0;
						link.port_select_low <= 1'b1;
						state <= H_GAP;
					end
				end
				H_GAP:
				begin
					if (half_end)
					begin
						tmr <= 32'h0;
						if (repoll)
						begin
							op <= OP_READ_STATUS;
							tot <= 17'h2;
							poll <= 1'b1;
							bi <= 17'h0;
							nbit <= 4'h0;
							sh <= {2'b00, OP_READ_STATUS};
							link.port_command_in <= OP_READ_STATUS[7];
							link.port_select_low <= 1'b0;
							state <= H_SPI;
						end
						else
						begin
							ready_o <= 1'b1;
							state <= H_IDLE;
						end
					end
				end
				default: state <= H_OFF;
			endcase
		end
	end

endmodule : fps_host

// [hdl/fps_link_if.sv]
// Pins between the programming host and the device.
// Assumes the bench drives no pin; the data line is pulled high when undriven.
`timescale 1ns/1ps
interface fps_link_if;
	logic chip_reset_low;
	logic program_mode_enable_low;
	logic port_select_low;
	logic port_serial_clock;
	logic port_command_in;
	logic port_data_out;
	logic port_data_oe;
	logic port_data_line;
	logic unlock_receive_a;
	logic unlock_receive_b;
	logic unlock_receive_c;

	assign port_data_line = port_data_oe ? port_data_out : 1'b1;

	modport device_mp(input chip_reset_low, input program_mode_enable_low, input port_select_low,
		input port_serial_clock, input port_command_in, input unlock_receive_a, input unlock_receive_b,
		input unlock_receive_c, output port_data_out, output port_data_oe);
	modport host_mp(output chip_reset_low, output program_mode_enable_low, output port_select_low,
		output port_serial_clock, output port_command_in, output unlock_receive_a,
		output unlock_receive_b, output unlock_receive_c, input port_data_line);
endinterface : fps_link_if

// [hdl/fps_pkg.sv]
// Shared constants and helpers for the flash programming slave port.
// Assumes a 20 MHz system clock on both ends of the link.
package fps_pkg;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned ENTRY_WAIT_MS = 10;
	localparam int unsigned ENTRY_WAIT_CYC = CLK_HZ / 1000 * ENTRY_WAIT_MS;
	localparam int unsigned ENTRY_MARGIN_CYC = 8;
	localparam int unsigned RESET_HIGH_MS = 1;
	localparam int unsigned RESET_HIGH_CYC = CLK_HZ / 1000 * RESET_HIGH_MS;
	localparam int unsigned SCLK_MAX_KHZ = 3330;
	localparam int unsigned SCLK_HALF_MIN = (CLK_HZ / 1000 + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
	localparam int unsigned UART_BAUD = 9600;
	localparam logic [11:0] UART_BIT_CYC = 12'(CLK_HZ / UART_BAUD);
	localparam logic [11:0] UART_HALF_CYC = 12'(CLK_HZ / UART_BAUD / 2);

	// ==========================================================
	// Commands and formats
	localparam logic [7:0] OP_READ_ID = 8'h9F;
	localparam logic [7:0] OP_READ_STATUS = 8'hD7;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h50;
	localparam logic [7:0] OP_BULK_ERASE = 8'hC7;
	localparam logic [7:0] OP_WRITE_PROG = 8'h44;
	localparam logic [23:0] BULK_KEY = 24'h94809A;
	localparam logic [4:0] STATUS_FIXED = 5'h07;
	localparam logic [31:0] UNLOCK_COOKIE = 32'h56874312;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [7:0] PIN_IDLE = 8'hEF;
	localparam int unsigned PAGE_LSB = 11;
	localparam int unsigned FLASH_BYTES = 524288;
	localparam logic [16:0] MAX_WRITE_BYTES = 17'h04000;

	// ==========================================================
	// Helpers
	function automatic logic fps_has_addr(input logic [7:0] op);
		return op == OP_READ || op == OP_PAGE_ERASE || op == OP_BULK_ERASE || op == OP_WRITE_PROG;
	endfunction : fps_has_addr

	function automatic logic [7:0] fps_unlock_byte(input logic [2:0] idx, input logic [31:0] key);
		logic [63:0] seq;
		seq = {key, UNLOCK_COOKIE};
		return seq[8 * idx +: 8];
	endfunction : fps_unlock_byte

endpackage : fps_pkg
